// *** design/sadc_decoder.sv ***
// serial instruction decoder of a 12-bit-plus-sign converter
// assumes clk is the conversion clock and linkClk the host's serial clock
//
// Contract
// - first two bits choose input pairing
// - conversion nibble picks length and bit order
// - sign off/on commands, no conversion started
// - acquisition 6/10/18/34 cycles, format kept
// - zero address: calibrate, zero, power, status, mode
// - reset: 10 cycles, 13-bit MSB first, powered
// - all pins low: decode and execute instruction
// - inhibit reads only; select high idle; sleep wins
// - nine-bit status word layout
// - result shifts out during following instruction
`timescale 1ns/100ps
module sadc_decoder
    import sadc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic linkClk,
    input wire logic chipSelectN,
    input wire logic convertN,
    input wire logic sleepRequest,
    input wire logic serialInstructionIn,
    input wire logic [RESULT_BITS-1:0] convResult,
    output logic dataOut,
    output logic dataOutEnN,
    output logic [1:0] inputSelect,
    output logic testMode,
    output logic sleeping,
    output logic sampling,
    output logic converting,
    output logic calibrating,
    output logic [STATUS_BITS-1:0] deviceStatusWord
);

    // link domain
    logic frameRst_n;
    logic [4:0] bitCnt_q;
    logic [4:0] bitCnt_d;
    logic [INSTR_BITS-1:0] instrShift_q;
    logic convInhibit_q;
    logic dataOut_q;
    logic dataOutEnN_q;
    sadc_instr_t instrHold_q;
    logic reqTgl_q;
    logic ackLink;
    logic pubLink;
    logic pubSeen_q;
    sadc_word_t linkWord_q;
    sadc_word_t wordNow;
    logic loadWord;

    // conversion clock domain
    logic reqClk;
    logic ackClk;
    logic pdClk;
    logic pdPrev_q;
    logic reqSeen_q;
    logic fifoInReady;
    logic fifoOutValid;
    logic fifoPop;
    sadc_instr_t cmd;
    logic pubBusy;
    logic pubTgl_q;
    sadc_word_t outWord_q;
    sadc_state_t state_q;
    logic [11:0] cnt_q;
    sadc_fmt_t fmt_q;
    sadc_fmt_t fmtNew;
    logic [1:0] acqSel_q;
    logic [11:0] acqCycles;
    logic autoZero_q;
    logic softDown_q;
    logic testMode_q;
    logic [1:0] muxSel_q;
    logic [RESULT_BITS-1:0] lastResult_q;
    logic sleepNow;
    logic convEnd;
    logic [STATUS_BITS-1:0] status;
    logic [3:0] mode;
    logic addrZero;
    logic isConv;
    logic isTest;
    logic isSign;
    logic isAcq;
    logic doCmd;
    logic [1:0] inputSelect_q;
    logic testModeOut_q;
    logic sleeping_q;
    logic sampling_q;
    logic converting_q;
    logic calibrating_q;
    logic [STATUS_BITS-1:0] status_q;

    // word bit k is the k-th bit shifted out
    function automatic sadc_word_t fmtWord(input logic [RESULT_BITS-1:0] r, input sadc_fmt_t f);
        logic [WORD_BITS-1:0] v;
        logic [4:0] idx;
        sadc_word_t w;
        v = {5'h00, r[11:0]};
        if (f.sign && f.len16)
        begin
            v = {{5{r[12]}}, r[11:0]};
        end
        else if (f.sign)
        begin
            v = {4'h0, r};
        end
        w.len = f.len16 ? (f.sign ? LEN_17 : LEN_16) : (f.sign ? LEN_13 : LEN_12);
        w.bits = v;
        if (f.msbFirst)
        begin
            for (int k = 0; k < WORD_BITS; k++)
            begin
                idx = w.len - 5'(k) - 5'h01;
                w.bits[k] = (5'(k) < w.len) ? v[idx] : 1'b0;
            end
        end
        return w;
    endfunction : fmtWord

    sadc_sync syncReq (.dstClk(clk), .arst_n(arst_n), .asyncIn(reqTgl_q), .syncOut(reqClk));
    sadc_sync syncAck (.dstClk(clk), .arst_n(arst_n), .asyncIn(pubSeen_q), .syncOut(ackClk));
    sadc_sync syncPd (.dstClk(clk), .arst_n(arst_n), .asyncIn(sleepRequest), .syncOut(pdClk));
    sadc_sync syncReqAck (.dstClk(linkClk), .arst_n(arst_n), .asyncIn(reqSeen_q),
        .syncOut(ackLink));
    sadc_sync syncPub (.dstClk(linkClk), .arst_n(arst_n), .asyncIn(pubTgl_q), .syncOut(pubLink));

    // chip select high ends the frame at once; linkClk may stop between frames
    assign frameRst_n = arst_n & ~chipSelectN;
    assign loadWord = (bitCnt_q == BIT_FIRST) && (pubLink != pubSeen_q);
    assign wordNow = loadWord ? outWord_q : linkWord_q;
    // continuous select wraps after exactly one word length
    assign bitCnt_d = (bitCnt_q + 5'h01 == wordNow.len) ? BIT_FIRST : bitCnt_q + 5'h01;

    always_ff @(posedge linkClk or negedge frameRst_n)
    begin
        if (!frameRst_n)
        begin
            bitCnt_q <= BIT_FIRST;
            instrShift_q <= '0;
            convInhibit_q <= 1'b0;
            dataOut_q <= 1'b0;
            dataOutEnN_q <= 1'b1;
        end
        else
        begin
            bitCnt_q <= bitCnt_d;
            dataOutEnN_q <= 1'b0;
            dataOut_q <= wordNow.bits[bitCnt_q];
            if (bitCnt_q <= INSTR_LAST)
            begin
                instrShift_q <= {serialInstructionIn, instrShift_q[INSTR_BITS-1:1]};
            end
            if (bitCnt_q == BIT_FIRST)
            begin
                convInhibit_q <= convertN;
            end
        end
    end

    // holder stays put until the conversion side echoes the toggle
    always_ff @(posedge linkClk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            instrHold_q <= '0;
            reqTgl_q <= 1'b0;
            linkWord_q <= WORD_RESET;
            pubSeen_q <= 1'b0;
        end
        else
        begin
            if (bitCnt_q == INSTR_LAST && reqTgl_q == ackLink)
            begin
                instrHold_q <= '{inhibit: convInhibit_q,
                    bits: {serialInstructionIn, instrShift_q[INSTR_BITS-1:1]}};
                reqTgl_q <= ~reqTgl_q;
            end
            if (loadWord)
            begin
                linkWord_q <= outWord_q;
                pubSeen_q <= pubLink;
            end
        end
    end

    // a full queue withholds the echo, which stalls later captures
    sadc_fifo #(.WIDTH($bits(sadc_instr_t)), .DEPTH(FIFO_DEPTH)) cmdFifo (
        .clk(clk),
        .arst_n(arst_n),
        .inValid(reqClk != reqSeen_q),
        .inReady(fifoInReady),
        .inData(instrHold_q),
        .outValid(fifoOutValid),
        .outReady(state_q == S_IDLE && !pubBusy),
        .outData(cmd)
    );

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reqSeen_q <= 1'b0;
        end
        else if (reqClk != reqSeen_q && fifoInReady)
        begin
            reqSeen_q <= reqClk;
        end
    end

    // status is never read mid-conversion: pops wait for idle
    assign pubBusy = pubTgl_q != ackClk;
    assign fifoPop = fifoOutValid && state_q == S_IDLE && !pubBusy;
    assign doCmd = fifoPop && !cmd.inhibit;
    assign mode = {cmd.bits[4], cmd.bits[5], cmd.bits[6], cmd.bits[7]};
    assign addrZero = cmd.bits[3:0] == 4'h0;
    assign isConv = !cmd.bits[4] && !cmd.bits[6];
    assign isTest = cmd.bits[0] && mode == MODE_USER;
    assign isSign = cmd.bits[3:1] == 3'h0 && mode == MODE_SIGN;
    assign isAcq = cmd.bits[3:2] == 2'h0 && mode == MODE_ACQ;
    assign sleepNow = pdClk || softDown_q;
    assign convEnd = state_q == S_CONV && cnt_q == 12'h000;

    always_comb
    begin
        unique case (acqSel_q)
            2'h0: acqCycles = ACQ_CYC_6;
            2'h1: acqCycles = ACQ_CYC_10;
            2'h2: acqCycles = ACQ_CYC_18;
            2'h3: acqCycles = ACQ_CYC_34;
        endcase
    end

    always_comb
    begin
        fmtNew = fmt_q;
        if (doCmd && isConv)
        begin
            fmtNew.len16 = cmd.bits[IB_LEN16];
            fmtNew.msbFirst = !cmd.bits[IB_LSB_FIRST];
        end
        else if (doCmd && isSign)
        begin
            fmtNew.sign = cmd.bits[0];
        end
    end

    always_comb
    begin
        status = '0;
        status[ST_WAKE] = state_q == S_WAKE;
        status[ST_DOWN] = sleepNow;
        status[ST_CAL] = state_q == S_CAL;
        status[ST_LEN12] = !fmt_q.len16;
        status[ST_LEN16] = fmt_q.len16;
        status[ST_SIGN] = fmt_q.sign;
        status[ST_MSB] = fmt_q.msbFirst;
        status[ST_TEST] = testMode_q;
    end

    // configuration
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fmt_q <= FMT_RESET;
            acqSel_q <= ACQ_SEL_RESET;
            autoZero_q <= 1'b0;
            softDown_q <= 1'b0;
            testMode_q <= 1'b0;
            muxSel_q <= 2'h0;
        end
        else
        begin
            fmt_q <= fmtNew;
            if (doCmd && isConv)
            begin
                muxSel_q <= cmd.bits[1:0];
            end
            if (doCmd && isAcq)
            begin
                acqSel_q <= {cmd.bits[0], cmd.bits[1]};
            end
            if (doCmd && isTest)
            begin
                testMode_q <= 1'b1;
            end
            else if (doCmd && addrZero && mode == MODE_USER)
            begin
                testMode_q <= 1'b0;
            end
            if (doCmd && addrZero && mode == MODE_ZERO)
            begin
                autoZero_q <= 1'b1;
            end
            else if (state_q == S_ZERO)
            begin
                autoZero_q <= 1'b0;
            end
            if (doCmd && addrZero && mode == MODE_DOWN)
            begin
                softDown_q <= 1'b1;
            end
            else if (doCmd && addrZero && mode == MODE_UP)
            begin
                softDown_q <= 1'b0;
            end
        end
    end

    // converter sequencing; the sleep pin aborts whatever runs
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= S_IDLE;
            cnt_q <= 12'h000;
            pdPrev_q <= 1'b0;
        end
        else
        begin
            pdPrev_q <= pdClk;
            cnt_q <= cnt_q - ONE_CYCLE;
            unique case (state_q)
                S_IDLE:
                begin
                    if (pdClk)
                    begin
                        state_q <= S_IDLE;
                    end
                    else if (pdPrev_q && !softDown_q)
                    begin
                        state_q <= S_WAKE;
                        cnt_q <= WAKE_CYCLES - ONE_CYCLE;
                    end
                    else if (doCmd && isConv && !softDown_q)
                    begin
                        state_q <= autoZero_q ? S_ZERO : S_ACQ;
                        cnt_q <= (autoZero_q ? ZERO_CYCLES : acqCycles) - ONE_CYCLE;
                    end
                    else if (doCmd && addrZero && mode == MODE_CAL && !softDown_q)
                    begin
                        state_q <= S_CAL;
                        cnt_q <= CAL_CYCLES - ONE_CYCLE;
                    end
                    else if (doCmd && addrZero && mode == MODE_UP && softDown_q)
                    begin
                        state_q <= S_WAKE;
                        cnt_q <= WAKE_CYCLES - ONE_CYCLE;
                    end
                end
                S_ZERO:
                begin
                    if (cnt_q == 12'h000)
                    begin
                        state_q <= S_ACQ;
                        cnt_q <= acqCycles - ONE_CYCLE;
                    end
                end
                S_ACQ:
                begin
                    if (cnt_q == 12'h000)
                    begin
                        state_q <= S_CONV;
                        cnt_q <= CONV_CYCLES - ONE_CYCLE;
                    end
                end
                S_CONV, S_CAL, S_WAKE:
                begin
                    if (cnt_q == 12'h000)
                    begin
                        state_q <= S_IDLE;
                    end
                end
                default:
                begin
                    state_q <= S_IDLE;
                end
            endcase
            if (pdClk)
            begin
                state_q <= S_IDLE;
            end
        end
    end

    // words handed to the link; one in flight at a time
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            outWord_q <= WORD_RESET;
            pubTgl_q <= 1'b0;
            lastResult_q <= '0;
        end
        else if (convEnd && !pdClk)
        begin
            lastResult_q <= convResult;
            outWord_q <= fmtWord(convResult, fmt_q);
            pubTgl_q <= ~pubTgl_q;
        end
        else if (doCmd && addrZero && mode == MODE_STATUS)
        begin
            outWord_q <= fmtWord({4'h0, status}, fmt_q);
            pubTgl_q <= ~pubTgl_q;
        end
        else if (doCmd && isSign)
        begin
            outWord_q <= fmtWord(lastResult_q, fmtNew);
            pubTgl_q <= ~pubTgl_q;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            inputSelect_q <= 2'h0;
            testModeOut_q <= 1'b0;
            sleeping_q <= 1'b0;
            sampling_q <= 1'b0;
            converting_q <= 1'b0;
            calibrating_q <= 1'b0;
            status_q <= '0;
        end
        else
        begin
            inputSelect_q <= muxSel_q;
            testModeOut_q <= testMode_q;
            sleeping_q <= sleepNow;
            sampling_q <= state_q == S_ACQ;
            converting_q <= state_q == S_CONV;
            calibrating_q <= state_q == S_CAL;
            status_q <= status;
        end
    end

    assign dataOut = dataOut_q;
    assign dataOutEnN = dataOutEnN_q;
    assign inputSelect = inputSelect_q;
    assign testMode = testModeOut_q;
    assign sleeping = sleeping_q;
    assign sampling = sampling_q;
    assign converting = converting_q;
    assign calibrating = calibrating_q;
    assign deviceStatusWord = status_q;

endmodule : sadc_decoder

// *** design/sadc_pkg.sv ***
// constants, types and encodings shared by the serial instruction decoder
// assumes bit i of an instruction byte is the i-th bit shifted in
package sadc_pkg;

    localparam int INSTR_BITS = 8;
    localparam int WORD_BITS = 17;
    localparam int RESULT_BITS = 13;
    localparam int STATUS_BITS = 9;
    localparam int FIFO_DEPTH = 16;

    // serial word lengths, in link clock cycles
    localparam logic [4:0] LEN_12 = 5'h0C;
    localparam logic [4:0] LEN_13 = 5'h0D;
    localparam logic [4:0] LEN_16 = 5'h10;
    localparam logic [4:0] LEN_17 = 5'h11;
    localparam logic [4:0] BIT_FIRST = 5'h00;
    localparam logic [4:0] INSTR_LAST = 5'h07;

    // mode nibble, written first-bit-leftmost (bit 4, 5, 6, 7)
    localparam logic [3:0] MODE_CAL = 4'h8;
    localparam logic [3:0] MODE_ZERO = 4'h9;
    localparam logic [3:0] MODE_UP = 4'hA;
    localparam logic [3:0] MODE_DOWN = 4'hB;
    localparam logic [3:0] MODE_STATUS = 4'hC;
    localparam logic [3:0] MODE_SIGN = 4'hD;
    localparam logic [3:0] MODE_ACQ = 4'hE;
    localparam logic [3:0] MODE_USER = 4'hF;

    // instruction bit positions
    localparam int IB_LSB_FIRST = 5;
    localparam int IB_LEN16 = 7;

    // acquisition times in conversion clock cycles, by select code
    localparam logic [1:0] ACQ_SEL_RESET = 2'h1;
    localparam logic [11:0] ACQ_CYC_6 = 12'h006;
    localparam logic [11:0] ACQ_CYC_10 = 12'h00A;
    localparam logic [11:0] ACQ_CYC_18 = 12'h012;
    localparam logic [11:0] ACQ_CYC_34 = 12'h022;
    // converter sequencing durations; plain defaults
    localparam logic [11:0] CONV_CYCLES = 12'h02C;
    localparam logic [11:0] CAL_CYCLES = 12'h100;
    localparam logic [11:0] ZERO_CYCLES = 12'h020;
    localparam logic [11:0] WAKE_CYCLES = 12'h040;
    localparam logic [11:0] ONE_CYCLE = 12'h001;

    // status word bit positions
    localparam int ST_WAKE = 0;
    localparam int ST_DOWN = 1;
    localparam int ST_CAL = 2;
    localparam int ST_LEN12 = 4;
    localparam int ST_LEN16 = 5;
    localparam int ST_SIGN = 6;
    localparam int ST_MSB = 7;
    localparam int ST_TEST = 8;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_WAKE = 3'b001,
        S_ZERO = 3'b010,
        S_ACQ = 3'b011,
        S_CONV = 3'b100,
        S_CAL = 3'b101
    } sadc_state_t;

    typedef struct packed {
        logic inhibit;
        logic [INSTR_BITS-1:0] bits;
    } sadc_instr_t;

    typedef struct packed {
        logic sign;
        logic len16;
        logic msbFirst;
    } sadc_fmt_t;

    typedef struct packed {
        logic [4:0] len;
        logic [WORD_BITS-1:0] bits;
    } sadc_word_t;

    localparam sadc_fmt_t FMT_RESET = '{sign: 1'b1, len16: 1'b0, msbFirst: 1'b1};
    localparam sadc_word_t WORD_RESET = '{len: LEN_13, bits: 17'h00000};

endpackage : sadc_pkg

// *** design/sadc_sync.sv ***
// two-flop synchroniser for one level into the domain of dstClk
// assumes the source changes no faster than the destination can follow
`timescale 1ns/100ps
module sadc_sync
(
    input wire logic dstClk,
    input wire logic arst_n,
    input wire logic asyncIn,
    output logic syncOut
);

    logic meta_q;
    logic sync_q;

    always_ff @(posedge dstClk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= asyncIn;
            sync_q <= meta_q;
        end
    end

    assign syncOut = sync_q;

endmodule : sadc_sync

// *** design/sadc_fifo.sv ***
// single-clock fifo with valid/ready on both sides
// assumes DEPTH is a power of two
`timescale 1ns/100ps
module sadc_fifo
#(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_q;
    logic [AW:0] rdPtr_q;
    logic push;
    logic pop;

    assign outValid = wrPtr_q != rdPtr_q;
    assign inReady = (wrPtr_q[AW] == rdPtr_q[AW]) || (wrPtr_q[AW-1:0] != rdPtr_q[AW-1:0]);
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outData = mem[rdPtr_q[AW-1:0]];

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wrPtr_q[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (pop)
            begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
        end
    end

endmodule : sadc_fifo

// *** testbench/sadc_decoder_monitor.sv ***
// port checks for the decoder, conversion clock domain
// assumes it is bound to the decoder top
`timescale 1ns/100ps
module sadc_decoder_monitor
    import sadc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic chipSelectN,
    input wire logic sleepRequest,
    input wire logic dataOutEnN,
    input wire logic sleeping,
    input wire logic sampling,
    input wire logic converting,
    input wire logic calibrating,
    input wire logic testMode,
    input wire logic [STATUS_BITS-1:0] deviceStatusWord
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // pin passes a two-flop synchroniser first
    sequence pinHeld;
        sleepRequest [*4];
    endsequence
    sequence acqStart;
        $rose(sampling);
    endsequence

    a_status_unused: assert property ($past(arst_n) |-> !deviceStatusWord[3])
        else $error("status bit 3 set");
    a_format_onehot: assert property ($past(arst_n) |->
        deviceStatusWord[ST_LEN12] != deviceStatusWord[ST_LEN16])
        else $error("format bits not one-hot");
    a_sleep_pin: assert property (pinHeld |-> ##[0:3] sleeping)
        else $error("sleep pin ignored");
    a_idle_released: assert property (chipSelectN && $past(chipSelectN) |-> dataOutEnN)
        else $error("output driven while idle");
    a_acq_min: assert property (acqStart |-> sampling [*6])
        else $error("acquisition too short");
    a_conv_bound: assert property ($rose(converting) |-> ##[40:48] !converting)
        else $error("conversion length wrong");
    a_cal_hold: assert property ($rose(calibrating) |-> calibrating [*8])
        else $error("calibration cut short");
    a_test_status: assert property (testMode && $past(testMode, 2) |->
        deviceStatusWord[ST_TEST])
        else $error("test flag missing in status");
endmodule : sadc_decoder_monitor

bind sadc_decoder sadc_decoder_monitor mon (.clk(clk), .arst_n(arst_n),
    .chipSelectN(chipSelectN), .sleepRequest(sleepRequest), .dataOutEnN(dataOutEnN),
    .sleeping(sleeping), .sampling(sampling), .converting(converting),
    .calibrating(calibrating), .testMode(testMode), .deviceStatusWord(deviceStatusWord));

// *** testbench/sadc_host_model.sv ***
// host side of the serial link: clocks frames and collects the returned word
// assumes the decoder samples on rising link clock edges
`timescale 1ns/100ps
module sadc_host_model
(
    output logic linkClk,
    output logic chipSelectN,
    output logic convertN,
    output logic serialInstructionIn,
    input wire logic dataOut
);
    initial
    begin
        linkClk = 1'b0;
        chipSelectN = 1'b1;
        convertN = 1'b0;
        serialInstructionIn = 1'b0;
    end

    // idle clocks with select high let the word handshake settle
    task automatic ticks(input int n);
        repeat (n)
        begin
            #6 linkClk = 1'b1;
            #6 linkClk = 1'b0;
        end
    endtask : ticks

    // strobed frame, data changes on the falling edge
    task automatic xfer(input logic [7:0] b, input int n, input logic inh,
        output logic [16:0] rx);
        rx = '0;
        ticks(3);
        chipSelectN = 1'b0;
        convertN = inh;
        for (int k = 0; k < n; k++)
        begin
            serialInstructionIn = (k < 8) ? b[k] : ~serialInstructionIn;
            #6 linkClk = 1'b1;
            #6 linkClk = 1'b0;
            rx[k] = dataOut;
        end
        chipSelectN = 1'b1;
        convertN = 1'b0;
        // released line shows no stale value
        serialInstructionIn = ~serialInstructionIn;
    endtask : xfer
endmodule : sadc_host_model

// *** testbench/sadc_decoder_tb.sv ***
// self-checking bench: conversions, formats, commands, sleep pin
// assumes the host model owns every link-side input
`timescale 1ns/100ps
module sadc_decoder_tb
    import sadc_pkg::*;
();
    logic clk, arst_n, sleepRequest;
    logic [RESULT_BITS-1:0] convResult;
    logic linkClk, chipSelectN, convertN, serialInstructionIn;
    logic dataOut, dataOutEnN, testMode, sleeping, sampling, converting, calibrating;
    logic [1:0] inputSelect;
    logic [STATUS_BITS-1:0] deviceStatusWord;
    logic [16:0] rx, expW;
    logic s, l16, msb;
    int err_total, checks, w;
    int acqTotal = 0, acqMark = 0;
    logic [7:0] acqOp [4] = '{8'h70, 8'h72, 8'h71, 8'h73};
    logic [11:0] acqCyc [4] = '{ACQ_CYC_6, ACQ_CYC_10, ACQ_CYC_18, ACQ_CYC_34};
    logic [7:0] convOp [4] = '{8'h00, 8'h81, 8'h22, 8'hA3};
    logic [7:0] cmdOp [6] = '{8'h10, 8'h90, 8'hD0, 8'h50, 8'hF1, 8'hF0};
    logic [2:0] cmdExp [6] = '{3'h0, 3'h0, 3'h2, 3'h0, 3'h1, 3'h0};

    sadc_decoder dut (.clk(clk), .arst_n(arst_n), .linkClk(linkClk),
        .chipSelectN(chipSelectN), .convertN(convertN), .sleepRequest(sleepRequest),
        .serialInstructionIn(serialInstructionIn), .convResult(convResult),
        .dataOut(dataOut), .dataOutEnN(dataOutEnN), .inputSelect(inputSelect),
        .testMode(testMode), .sleeping(sleeping), .sampling(sampling),
        .converting(converting), .calibrating(calibrating),
        .deviceStatusWord(deviceStatusWord));
    sadc_host_model host (.linkClk(linkClk), .chipSelectN(chipSelectN),
        .convertN(convertN), .serialInstructionIn(serialInstructionIn), .dataOut(dataOut));

    always #10 clk = ~clk;

    task automatic chk(input string nm, input logic [16:0] got, input logic [16:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    // bit k is the k-th bit on the wire; sign copies fill the signed long word, zeros the unsigned one
    function automatic logic [16:0] fmtWord(input logic [12:0] r);
        int n;
        int j;
        fmtWord = '0;
        n = (l16 ? 16 : 12) + int'(s);
        for (int k = 0; k < n; k++)
        begin
            j = msb ? n - 1 - k : k;
            fmtWord[k] = (j < 12) ? r[j] : (s & r[12]);
        end
    endfunction : fmtWord

    task automatic frame(input logic [7:0] b, input logic inh, input string nm);
        host.xfer(b, (l16 ? 16 : 12) + int'(s), inh, rx);
        chk(nm, rx, expW);
        repeat (20) @(posedge clk);
    endtask : frame

    // counted as it happens: a short acquisition ends before the frame task returns
    always @(negedge clk)
        if (sampling)
            acqTotal++;

    // waits out acquisition and conversion, then reports the acquisition width
    task automatic convWait(output int cyc);
        repeat (100) @(posedge clk);
        chk("conv done", 17'({sampling, converting}), 17'h0);
        cyc = acqTotal - acqMark;
        acqMark = acqTotal;
    endtask : convWait

    initial
    begin
        #400000;
        err_total++;
        tally_and_finish();
    end

    initial
    begin
        clk = 1'b0;
        arst_n = 1'b0;
        sleepRequest = 1'b0;
        convResult = '0;
        err_total = 0;
        checks = 0;
        s = 1'b1;
        l16 = 1'b0;
        msb = 1'b1;
        expW = '0;
        fork
            host.ticks(4);
            repeat (4) @(posedge clk);
        join
        arst_n <= 1'b1;
        repeat (100) @(posedge clk);
        chk("status", 17'(deviceStatusWord), 17'h000D0);
        chk("idle", 17'({dataOutEnN, sleeping}), 17'h2);
        for (int i = 0; i < 4; i++)
        begin
            frame(acqOp[i], 1'b0, "acq word");
            convResult <= 13'h1A5C ^ 13'(i * 'h0333);
            frame(convOp[i], 1'b0, "conv word");
            convWait(w);
            chk("acquire", 17'(w), 17'(acqCyc[i]));
            chk("select", 17'(inputSelect), 17'(convOp[i][1:0]));
            l16 = convOp[i][IB_LEN16];
            msb = !convOp[i][IB_LSB_FIRST];
            expW = fmtWord(convResult);
            $display("test format %0d done", i);
        end
        frame(8'hB0, 1'b0, "sign off");
        s = 1'b0;
        expW = fmtWord(convResult);
        frame(8'hB1, 1'b0, "sign on");
        s = 1'b1;
        expW = fmtWord(convResult);
        frame(8'h30, 1'b0, "status cmd");
        // 16/17 LSB first with sign, user mode, idle
        expW = fmtWord(13'h0060);
        chk("status reg", 17'(deviceStatusWord), 17'h00060);
        frame(8'h30, 1'b0, "status out");
        convResult <= 13'h0F0F;
        frame(8'h00, 1'b1, "read only");
        convWait(w);
        chk("no conversion", 17'(w), 17'h0);
        $display("test sign and status done");
        for (int i = 0; i < 6; i++)
        begin
            frame(cmdOp[i], 1'b0, "command");
            if (i == 0)
                chk("cal busy", 17'(calibrating), 17'h1);
            repeat (300) @(posedge clk);
            chk("cmd", 17'({calibrating, sleeping, testMode}), 17'(cmdExp[i]));
        end
        $display("test commands done");
        sleepRequest <= 1'b1;
        repeat (8) @(posedge clk);
        chk("pin sleep", 17'({sleeping, deviceStatusWord[ST_DOWN]}), 17'h3);
        sleepRequest <= 1'b0;
        repeat (150) @(posedge clk);
        chk("pin wake", 17'(sleeping), 17'h0);
        $display("test sleep pin done");
        tally_and_finish();
    end
endmodule : sadc_decoder_tb
